/* shared/ppc_consts.vh */
// Register indices, reset values and field positions for the panel timing block
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// Register indices; the byte address is four times the index
`define PPC_IDX_TYPE 16'h4000
`define PPC_IDX_BUSW 16'h4001
`define PPC_IDX_HTOT_LO 16'h4002
`define PPC_IDX_HTOT_HI 16'h4003
`define PPC_IDX_HDP_LO 16'h4004
`define PPC_IDX_HDP_HI 16'h4005
`define PPC_IDX_HDS_LO 16'h4006
`define PPC_IDX_HDS_HI 16'h4007
`define PPC_IDX_HPW_LO 16'h4008
`define PPC_IDX_HPW_POL 16'h4009
`define PPC_IDX_HPS_LO 16'h400a
`define PPC_IDX_HPS_HI 16'h400b
`define PPC_IDX_VTOT_LO 16'h400c
`define PPC_IDX_VTOT_HI 16'h400d
`define PPC_IDX_STATUS 16'h4020
`define PPC_ADDR_W 18

// Reset values
`define PPC_RST_TYPE 8'h88
`define PPC_RST_BUSW 8'h00

// Panel type select register fields
`define PPC_TYPE_P2MODE_HI 7
`define PPC_TYPE_P2MODE_LO 6
`define PPC_TYPE_P2TYPE_HI 5
`define PPC_TYPE_P2TYPE_LO 4
`define PPC_TYPE_CAM_BIT 3
`define PPC_TYPE_P1MODE_BIT 2
`define PPC_TYPE_AUDPIN_BIT 1

// Bus width / clock edge register fields
`define PPC_BUSW_P2POL_BIT 7
`define PPC_BUSW_P2W_HI 6
`define PPC_BUSW_P2W_LO 4
`define PPC_BUSW_P1POL_BIT 3
`define PPC_BUSW_P1W_HI 1
`define PPC_BUSW_P1W_LO 0

// Field codes
`define PPC_P2_GENERIC 2'h0
`define PPC_P2_SPLIT 2'h1
`define PPC_P2_DUALVIEW 2'h2
`define PPC_W_12 3'h0
`define PPC_W_16 3'h1
`define PPC_W_18 3'h2
`define PPC_W_24 3'h3

// Pixel formats
`define PPC_FMT_666 2'h0
`define PPC_FMT_555 2'h1
`define PPC_FMT_565 2'h2
`define PPC_FMT_444 2'h3

// Status register fields
`define PPC_ST_URUN_BIT 0
`define PPC_ST_CAM_BIT 1
`define PPC_ST_VCNT_LO 16

`endif

/* hdl/ppc_panel_timing.v */
// Panel port configuration registers, panel one raster timing and pixel output
//
// Operation
// - Port two type field: 00 generic, 01 split double-screen, 10 dual-view, 11 reserved.
// - Pin-assignment bit routes panel one pins to port one or camera; resets to one.
// - Mode bit zero: RGB without serial; 6:6:6, or 5:5:5 when port two borrows pins.
// - Mode bit one: RGB with serial; 5:6:5, or 4:4:4 when port two borrows pins.
// - Audio/PWM borrow bit one frees panel one pins; zero keeps audio pins.
// - Port two clock polarity bit: data valid rising edge at zero, falling at one.
// - Port two bus width code: 12, 16, 18, 24 bits; higher codes reserved.
// - Panel one clock polarity bit: data valid rising edge at zero, falling at one.
// - Horizontal total is line length minus one, in pixel clocks.
// - Active width field is half width minus one; width stays below total.
// - Vertical total is lines per frame minus one.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"

module ppc_panel_timing #(
	parameter DW = 24,
	parameter OW = 18
) (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`PPC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Pixel clock from the panel side
	input wire pix_clk_in,
	// Pixel stream in
	input wire in_valid,
	input wire [DW-1:0] in_data,
	output reg in_ready,
	// Panel one pins
	output reg panel_clk,
	output reg panel_de,
	output reg panel_hsync,
	output reg panel_first_line,
	output reg [OW-1:0] panel_data,
	// Pin routing and port two configuration
	output reg second_camera_input_sel,
	output reg audio_pins_to_panel,
	output reg [1:0] p2_panel_type,
	output reg [1:0] p2_panel_mode,
	output reg [4:0] p2_bus_bits,
	output reg p2_clk_invert,
	output reg [1:0] p1_bus_width
);

	// Configuration registers
	reg [7:0] type_reg;
	reg [7:0] busw_reg;
	reg [11:0] htot_reg;
	reg [10:0] hdp_reg;
	reg [11:0] hds_reg;
	reg [8:0] hpw_reg;
	reg hpol_reg;
	reg [11:0] hps_reg;
	reg [11:0] vtot_reg;
	reg urun_reg;

	// APB answer state
	reg [31:0] rdata_next;
	reg hit_next;
	wire [15:0] idx = paddr[`PPC_ADDR_W-1:2];
	wire access = psel & penable;
	wire wr_done = access & pready & pwrite & pstrb[0] & ~pslverr;
	wire [7:0] wb = pwdata[7:0];

	// Pixel clock sampling
	reg pck_s1_reg;
	reg pck_s2_reg;
	reg pck_s3_reg;
	wire adv;

	// Raster counters
	reg [11:0] hcnt_reg;
	reg [11:0] vcnt_reg;
	wire [12:0] h_act_start;
	wire [12:0] h_act_end;
	wire [12:0] h_sync_end;
	wire de_now;
	wire hs_now;
	wire cam;
	wire [1:0] fmt;

	// Two-entry buffer
	reg [DW-1:0] mem [0:1];
	reg wr_ptr_reg;
	reg rd_ptr_reg;
	reg [1:0] cnt_reg;
	reg [1:0] cnt_next;
	wire push;
	wire pop;
	wire empty;
	wire underrun;

	// Keep the top bits of each colour of an 8:8:8 word
	function [OW-1:0] pack_rgb;
		input [1:0] f;
		input [23:0] px;
		begin
			case (f)
				`PPC_FMT_666: pack_rgb = {px[23:18], px[15:10], px[7:2]};
				`PPC_FMT_555: pack_rgb = {3'h0, px[23:19], px[15:11], px[7:3]};
				`PPC_FMT_565: pack_rgb = {2'h0, px[23:19], px[15:10], px[7:3]};
				default: pack_rgb = {6'h00, px[23:20], px[15:12], px[7:4]};
			endcase
		end
	endfunction

	// Bits on the port two bus for a width code
	function [4:0] width_bits;
		input [2:0] code;
		begin
			case (code)
				`PPC_W_12: width_bits = 5'h0c;
				`PPC_W_16: width_bits = 5'h10;
				`PPC_W_18: width_bits = 5'h12;
				`PPC_W_24: width_bits = 5'h18;
				default: width_bits = 5'h00;
			endcase
		end
	endfunction

	// Read mux and address decode
	always @* begin
		rdata_next = 32'h0;
		hit_next = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			hit_next = 1'b0;
		end else begin
			case (idx)
				`PPC_IDX_TYPE: rdata_next[7:0] = type_reg;
				`PPC_IDX_BUSW: rdata_next[7:0] = busw_reg;
				`PPC_IDX_HTOT_LO: rdata_next[7:0] = htot_reg[7:0];
				`PPC_IDX_HTOT_HI: rdata_next[3:0] = htot_reg[11:8];
				`PPC_IDX_HDP_LO: rdata_next[7:0] = hdp_reg[7:0];
				`PPC_IDX_HDP_HI: rdata_next[2:0] = hdp_reg[10:8];
				`PPC_IDX_HDS_LO: rdata_next[7:0] = hds_reg[7:0];
				`PPC_IDX_HDS_HI: rdata_next[3:0] = hds_reg[11:8];
				`PPC_IDX_HPW_LO: rdata_next[7:0] = hpw_reg[7:0];
				`PPC_IDX_HPW_POL: rdata_next[7:0] = {hpol_reg, 6'h00, hpw_reg[8]};
				`PPC_IDX_HPS_LO: rdata_next[7:0] = hps_reg[7:0];
				`PPC_IDX_HPS_HI: rdata_next[3:0] = hps_reg[11:8];
				`PPC_IDX_VTOT_LO: rdata_next[7:0] = vtot_reg[7:0];
				`PPC_IDX_VTOT_HI: rdata_next[3:0] = vtot_reg[11:8];
				`PPC_IDX_STATUS: begin
					rdata_next[`PPC_ST_URUN_BIT] = urun_reg;
					rdata_next[`PPC_ST_CAM_BIT] = cam;
					rdata_next[`PPC_ST_VCNT_LO+11:`PPC_ST_VCNT_LO] = vcnt_reg;
				end
				default: hit_next = 1'b0;
			endcase
		end
	end

	// One wait state: answer in the second access cycle, write at that edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			if (access & ~pready) begin
				pready <= 1'b1;
				pslverr <= ~hit_next;
				prdata <= pwrite ? 32'h0 : rdata_next;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_reg <= `PPC_RST_TYPE;
			busw_reg <= `PPC_RST_BUSW;
			htot_reg <= 12'h000;
			hdp_reg <= 11'h000;
			hds_reg <= 12'h000;
			hpw_reg <= 9'h000;
			hpol_reg <= 1'b0;
			hps_reg <= 12'h000;
			vtot_reg <= 12'h000;
		end else if (ce && wr_done) begin
			case (idx)
				`PPC_IDX_TYPE: type_reg <= {wb[7:1], 1'b0};
				`PPC_IDX_BUSW: busw_reg <= {wb[7:3], 1'b0, wb[1:0]};
				`PPC_IDX_HTOT_LO: htot_reg[7:0] <= wb;
				`PPC_IDX_HTOT_HI: htot_reg[11:8] <= wb[3:0];
				`PPC_IDX_HDP_LO: hdp_reg[7:0] <= wb;
				`PPC_IDX_HDP_HI: hdp_reg[10:8] <= wb[2:0];
				`PPC_IDX_HDS_LO: hds_reg[7:0] <= wb;
				`PPC_IDX_HDS_HI: hds_reg[11:8] <= wb[3:0];
				`PPC_IDX_HPW_LO: hpw_reg[7:0] <= wb;
				`PPC_IDX_HPW_POL: begin
					hpw_reg[8] <= wb[0];
					hpol_reg <= wb[7];
				end
				`PPC_IDX_HPS_LO: hps_reg[7:0] <= wb;
				`PPC_IDX_HPS_HI: hps_reg[11:8] <= wb[3:0];
				`PPC_IDX_VTOT_LO: vtot_reg[7:0] <= wb;
				`PPC_IDX_VTOT_HI: vtot_reg[11:8] <= wb[3:0];
				default: ;
			endcase
		end
	end

	// Underrun flag, write one to clear; a new underrun wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			urun_reg <= 1'b0;
		end else if (ce) begin
			if (underrun)
				urun_reg <= 1'b1;
			else if (wr_done && idx == `PPC_IDX_STATUS && wb[`PPC_ST_URUN_BIT])
				urun_reg <= 1'b0;
		end
	end

	// Pin routing and port two configuration outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_camera_input_sel <= 1'b1;
			audio_pins_to_panel <= 1'b0;
			p2_panel_type <= `PPC_P2_GENERIC;
			p2_panel_mode <= 2'h0;
			p2_bus_bits <= 5'h00;
			p2_clk_invert <= 1'b0;
			p1_bus_width <= 2'h0;
		end else if (ce) begin
			second_camera_input_sel <= type_reg[`PPC_TYPE_CAM_BIT];
			audio_pins_to_panel <= type_reg[`PPC_TYPE_AUDPIN_BIT];
			p2_panel_type <= type_reg[`PPC_TYPE_P2TYPE_HI:`PPC_TYPE_P2TYPE_LO];
			p2_panel_mode <= type_reg[`PPC_TYPE_P2MODE_HI:`PPC_TYPE_P2MODE_LO];
			p2_bus_bits <= width_bits(busw_reg[`PPC_BUSW_P2W_HI:`PPC_BUSW_P2W_LO]);
			p2_clk_invert <= busw_reg[`PPC_BUSW_P2POL_BIT];
			p1_bus_width <= busw_reg[`PPC_BUSW_P1W_HI:`PPC_BUSW_P1W_LO];
		end
	end

	// Two-stage synchroniser plus one stage for edge finding
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pck_s1_reg <= 1'b0;
			pck_s2_reg <= 1'b0;
			pck_s3_reg <= 1'b0;
		end else if (ce) begin
			pck_s1_reg <= pix_clk_in;
			pck_s2_reg <= pck_s1_reg;
			pck_s3_reg <= pck_s2_reg;
		end
	end

	// Data changes on the edge opposite the one the panel latches on
	assign adv = busw_reg[`PPC_BUSW_P1POL_BIT] ? (pck_s2_reg & ~pck_s3_reg) :
		(~pck_s2_reg & pck_s3_reg);

	assign cam = type_reg[`PPC_TYPE_CAM_BIT];

	// Port two takes panel one pins only for a split panel without audio pins
	assign fmt = type_reg[`PPC_TYPE_P1MODE_BIT] ?
		((type_reg[`PPC_TYPE_P2TYPE_HI:`PPC_TYPE_P2TYPE_LO] == `PPC_P2_SPLIT &&
		!type_reg[`PPC_TYPE_AUDPIN_BIT]) ? `PPC_FMT_444 : `PPC_FMT_565) :
		((type_reg[`PPC_TYPE_P2TYPE_HI:`PPC_TYPE_P2TYPE_LO] == `PPC_P2_SPLIT &&
		!type_reg[`PPC_TYPE_AUDPIN_BIT]) ? `PPC_FMT_555 : `PPC_FMT_666);

	// Active window and sync window positions
	assign h_act_start = {1'b0, hds_reg} + 13'h0001;
	assign h_act_end = h_act_start + {1'b0, hdp_reg, 1'b0} + 13'h0002;
	assign h_sync_end = {1'b0, hps_reg} + {4'h0, hpw_reg} + 13'h0001;
	assign de_now = ({1'b0, hcnt_reg} >= h_act_start) && ({1'b0, hcnt_reg} < h_act_end);
	assign hs_now = (hcnt_reg >= hps_reg) && ({1'b0, hcnt_reg} < h_sync_end);

	// Raster counters advance once per pixel clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_reg <= 12'h000;
			vcnt_reg <= 12'h000;
		end else if (ce && adv) begin
			if (hcnt_reg >= htot_reg) begin
				hcnt_reg <= 12'h000;
				if (vcnt_reg >= vtot_reg)
					vcnt_reg <= 12'h000;
				else
					vcnt_reg <= vcnt_reg + 12'h001;
			end else begin
				hcnt_reg <= hcnt_reg + 12'h001;
			end
		end
	end

	// Buffer control
	assign push = in_valid & in_ready;
	assign empty = (cnt_reg == 2'h0);
	assign pop = adv & de_now & ~cam & ~empty;
	assign underrun = adv & de_now & ~cam & empty;

	always @* begin
		cnt_next = cnt_reg;
		if (push & ~pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop & ~push)
			cnt_next = cnt_reg - 2'h1;
	end

	// Ready is registered, so it drops as soon as the second entry fills
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
			in_ready <= 1'b0;
			mem[0] <= {DW{1'b0}};
			mem[1] <= {DW{1'b0}};
		end else if (ce) begin
			cnt_reg <= cnt_next;
			in_ready <= (cnt_next != 2'h2);
			if (push) begin
				mem[wr_ptr_reg] <= in_data;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
		end
	end

	// Panel pins; idle while the pins belong to the camera
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_clk <= 1'b0;
			panel_de <= 1'b0;
			panel_hsync <= 1'b1;
			panel_first_line <= 1'b0;
			panel_data <= {OW{1'b0}};
		end else if (ce) begin
			panel_clk <= cam ? 1'b0 : pck_s3_reg;
			if (cam) begin
				panel_de <= 1'b0;
				panel_hsync <= hpol_reg ? 1'b0 : 1'b1;
				panel_first_line <= 1'b0;
				panel_data <= {OW{1'b0}};
			end else if (adv) begin
				panel_de <= de_now;
				panel_hsync <= hpol_reg ? hs_now : ~hs_now;
				panel_first_line <= (vcnt_reg == 12'h000);
				panel_data <= pop ? pack_rgb(fmt, mem[rd_ptr_reg]) : {OW{1'b0}};
			end
		end
	end

endmodule

`default_nettype wire

/* bench/ppc_panel_timing_assertions.sv */
// Port-level checks for the panel timing block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"
module ppc_panel_assertions #(parameter OW = 18) (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// Panel and configuration
	input wire logic panel_de,
	input wire logic [OW-1:0] panel_data,
	input wire logic second_camera_input_sel,
	input wire logic [1:0] p2_panel_type,
	input wire logic [4:0] p2_bus_bits,
	input wire logic p2_clk_invert
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	function automatic logic [4:0] wbits(input logic [2:0] c);
		return c == 3'h0 ? 5'h0c : c == 3'h1 ? 5'h10 : c == 3'h2 ? 5'h12 : c == 3'h3 ? 5'h18 : 5'h00;
	endfunction
	sequence acc_first;
		ce && psel && penable && !pready;
	endsequence
	// Config outputs lag the register by one clock, hence the extra cycle
	sequence wr_reg(idx);
		psel && penable && pready && pwrite && pstrb[0] && paddr == {idx, 2'h0};
	endsequence
	wait_state_a: assert property (acc_first |=> pready ##1 !pready)
		else $error("access not answered after one wait state");
	bad_addr_a: assert property ((acc_first and (paddr[1:0] != 2'h0)) |=> pready && pslverr)
		else $error("misaligned access not refused");
	type_field_a: assert property (
		wr_reg(`PPC_IDX_TYPE) |=> ##1 p2_panel_type == $past(pwdata[5:4], 2))
		else $error("port two type wrong");
	cam_route_a: assert property (
		wr_reg(`PPC_IDX_TYPE) |=> ##1 second_camera_input_sel == $past(pwdata[3], 2))
		else $error("pin group route wrong");
	p2_edge_a: assert property (
		wr_reg(`PPC_IDX_BUSW) |=> ##1 p2_clk_invert == $past(pwdata[7], 2))
		else $error("port two edge wrong");
	bus_width_a: assert property (
		wr_reg(`PPC_IDX_BUSW) |=> ##1 p2_bus_bits == wbits($past(pwdata[6:4], 2)))
		else $error("port two width wrong");
	cam_idle_a: assert property (second_camera_input_sel [*3] |-> !panel_de)
		else $error("panel active while camera owns pins");
	data_idle_a: assert property (!panel_de |-> panel_data == '0)
		else $error("data outside active area");
endmodule
bind ppc_panel_timing ppc_panel_assertions #(.OW(OW)) chk (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .panel_de, .panel_data,
	.second_camera_input_sel, .p2_panel_type, .p2_bus_bits, .p2_clk_invert);
`default_nettype wire

/* bench/ppc_panel_model.sv */
// Flat panel model: makes the pixel clock and measures the raster
`timescale 1ns/1ps
`default_nettype none
module ppc_panel_model (
	// Bench control
	input wire logic run,
	input wire logic late_edge,
	input wire logic sync_high,
	// Panel pins
	output logic pix_clk_in,
	input wire logic panel_clk,
	input wire logic panel_de,
	input wire logic panel_hsync,
	input wire logic panel_first_line,
	input wire logic [17:0] panel_data
);
	int de_run, hs_run, hs_off, line_len, frame_len, de_n, hs_n, step, lines, hold_bad;
	realtime t_chg;
	logic de_d, hs_d, fl_d, hs;
	logic [17:0] seen_q[$];
	initial pix_clk_in = 1'b0;
	// Clock stands still while run is low, between passes
	always #16 pix_clk_in = run ? ~pix_clk_in : pix_clk_in;
	// Latest change of the DE, sync or data pins, to catch data moving next to the latch edge
	always @(panel_de or panel_hsync or panel_data) t_chg = $realtime;
	always @(panel_clk) if (panel_clk === !late_edge) begin
		hs = panel_hsync === sync_high;
		if ($realtime - t_chg < 8.0)
			hold_bad++;
		step++;
		if (panel_de)
			seen_q.push_back(panel_data);
		if (panel_de && !de_d) begin
			line_len = step;
			step = 0;
			lines++;
		end
		if (hs && !hs_d)
			hs_off = step;
		if (panel_first_line && !fl_d) begin
			frame_len = lines;
			lines = 0;
		end
		if (de_d && !panel_de)
			de_run = de_n;
		if (hs_d && !hs)
			hs_run = hs_n;
		de_n = panel_de ? de_n + 1 : 0;
		hs_n = hs ? hs_n + 1 : 0;
		de_d = panel_de;
		hs_d = hs;
		fl_d = panel_first_line;
	end
endmodule
`default_nettype wire

/* bench/ppc_panel_timing_tb_top.sv */
// Self-checking bench for the panel timing block
`timescale 1ns/1ps
`default_nettype none
module ppc_panel_timing_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic in_valid = 1'b0, run = 1'b0, late = 1'b0, shi = 1'b0, se;
	logic [17:0] paddr = 18'h0, panel_data;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [23:0] in_data = 24'h0;
	logic pready, pslverr, pix_clk_in, in_ready, panel_clk, panel_de, panel_hsync;
	logic panel_first_line, second_camera_input_sel, audio_pins_to_panel, p2_clk_invert;
	logic [1:0] p2_panel_type, t, p2_panel_mode, p1_bus_width;
	logic [4:0] p2_bus_bits;
	logic [7:0] rv, d, rg[14];
	logic [23:0] raw_q[$];
	int err_count = 0, samples_checked = 0, cyc = 0, i, p;
	logic [7:0] msk[14] = '{8'hfe, 8'hfb, 8'hff, 8'h0f, 8'hff, 8'h07, 8'hff, 8'h0f, 8'hff,
		8'h81, 8'hff, 8'h0f, 8'hff, 8'h0f};
	logic [4:0] wtab[8] = '{5'h0c, 5'h10, 5'h12, 5'h18, 5'h00, 5'h00, 5'h00, 5'h00};
	always #2 pclk = ~pclk;
	ppc_panel_timing #(.DW(24), .OW(18)) uut (.pclk, .presetn, .ce(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pix_clk_in, .in_valid,
		.in_data, .in_ready, .panel_clk, .panel_de, .panel_hsync, .panel_first_line,
		.panel_data, .second_camera_input_sel, .audio_pins_to_panel, .p2_panel_type,
		.p2_panel_mode, .p2_bus_bits, .p2_clk_invert, .p1_bus_width);
	ppc_panel_model model (.run, .late_edge(late), .sync_high(shi), .pix_clk_in, .panel_clk,
		.panel_de, .panel_hsync, .panel_first_line, .panel_data);
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// Register k sits at byte address four times (4000h + k)
	task automatic apb(input logic wr, input int k, input logic [7:0] dd,
		input logic [1:0] off = 2'h0);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {16'h4000 + k[15:0], off};
		pwdata <= {24'h0, dd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata[7:0];
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic feed(input int n);
		logic [23:0] w;
		repeat (n) begin
			w = 24'($urandom);
			in_valid <= 1'b1;
			in_data <= w;
			do @(posedge pclk); while (in_ready !== 1'b1);
			raw_q.push_back(w);
			in_valid <= 1'b0;
			repeat ($urandom_range(1, 3)) @(posedge pclk);
		end
	endtask
	// Colour MSBs packed low: 6:6:6, 5:5:5, 5:6:5, 4:4:4
	function automatic logic [17:0] pk(input logic [23:0] x, input logic [1:0] f);
		case (f)
			2'h0: return {x[23:18], x[15:10], x[7:2]};
			2'h1: return {3'h0, x[23:19], x[15:11], x[7:3]};
			2'h2: return {2'h0, x[23:19], x[15:10], x[7:3]};
			default: return {6'h0, x[23:20], x[15:12], x[7:4]};
		endcase
	endfunction
	// Ceiling well above six raster passes
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report;
		end
	end
	initial begin
		i = $urandom(97325);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 14; i++) begin
			apb(0, i, 8'h00);
			chk("reset", i ? 8'h00 : 8'h88, rv);
		end
		for (i = 0; i < 14; i++) begin
			d = 8'($urandom) & (i ? 8'hff : 8'hfe);
			apb(1, i, d);
			apb(0, i, 8'h00);
			chk("readback", d & msk[i], rv);
		end
		apb(0, 16'h30, 8'h00);
		chk("unmapped", 1'b1, se);
		apb(1, 0, 8'h00, 2'h2);
		chk("misaligned", 1'b1, se);
		// Write with byte lane zero off must leave the register alone
		apb(1, 2, 8'h11);
		pstrb <= 4'h0;
		apb(1, 2, 8'h5a);
		pstrb <= 4'hf;
		apb(0, 2, 8'h00);
		chk("strobe", 8'h11, rv);
		for (i = 0; i < 8; i++) begin
			t = 2'(i % 3);
			apb(1, 1, {i[0], i[2:0], 2'h0, i[1:0]});
			apb(1, 0, {i[2:1], t, i[0], 1'b0, i[1], 1'b0});
			repeat (2) @(posedge pclk);
			chk("width", wtab[i], p2_bus_bits);
			chk("edge", i[0], p2_clk_invert);
			chk("type", t, p2_panel_type);
			chk("route", i[0], second_camera_input_sel);
			chk("audio", i[1], audio_pins_to_panel);
			chk("mode", i[2:1], p2_panel_mode);
			chk("p1 width", i[1:0], p1_bus_width);
		end
		for (p = 0; p < 6; p++) begin
			run <= 1'b0;
			late <= p[1];
			shi <= p[0];
			t = p < 2 ? 2'h0 : 2'h1;
			rg = '{{2'h0, t, 1'b0, p[0], p > 3, 1'b0}, {4'h0, p[1], 3'h0}, 8'h27, 8'h00, 8'h03,
				8'h00, 8'(p), 8'h00, 8'(p + 1), {p[0], 7'h00}, 8'h14, 8'h00, 8'h02, 8'h00};
			for (i = 0; i < 14; i++)
				apb(1, i, rg[i]);
			model.seen_q.delete();
			// Stale figures from the last pass must not satisfy this one
			model.de_run = 0;
			model.line_len = 0;
			model.hs_run = 0;
			model.hs_off = 0;
			model.frame_len = 0;
			raw_q.delete();
			// Pixel clock stopped: nothing drains, so two words fill the buffer
			feed(2);
			repeat (2) @(posedge pclk);
			chk("ready full", 1'b0, in_ready);
			run <= 1'b1;
			feed(14);
			repeat (2300) @(posedge pclk);
			for (i = 0; i < 16; i++)
				chk("pixel", pk(raw_q[i], {p[0], t[0] && p < 4}), model.seen_q[i]);
			chk("de run", 8, model.de_run);
			chk("line", 40, model.line_len);
			chk("sync run", p + 2, model.hs_run);
			chk("sync pos", 19 - p, model.hs_off);
			chk("frame", 3, model.frame_len);
			chk("hold", 0, model.hold_bad);
		end
		run <= 1'b0;
		apb(0, 16'h20, 8'h00);
		chk("status", 2'h1, rv[1:0]);
		apb(1, 16'h20, 8'h01);
		apb(0, 16'h20, 8'h00);
		chk("status clr", 2'h0, rv[1:0]);
		final_report;
	end
endmodule
`default_nettype wire
